// ---- rtl/fol_pkg.sv ----
/*
  Constants for the fail output logic: filter times, counts, reset values.
  Assumes a single 10 MHz clock domain.
*/
package fol_pkg;
  // Clock period in ns
  localparam int ClockPeriodNs = 100;
  // Configuration select filter, typical and bounds in ns
  localparam int CfgFilterTypNs = 8000;
  localparam int CfgFilterMinNs = 6000;
  localparam int CfgFilterMaxNs = 10000;
  localparam int CfgFilterCycles = CfgFilterTypNs / ClockPeriodNs;
  // Fail/test pin filter, typical and bounds in ns
  localparam int TestFilterTypNs = 64000;
  localparam int TestFilterMinNs = 52000;
  localparam int TestFilterMaxNs = 81000;
  localparam int TestFilterCycles = TestFilterTypNs / ClockPeriodNs;
  // Undervoltage detections that trip the fail output
  localparam int UvTripCount = 4;
  // Filter counter width
  localparam int FiltW = 10;
  // Reset values
  localparam logic ResetFailOut = 1'h0;
  localparam logic ResetFlag = 1'h0;
  localparam logic ResetCfgSingleWd = 1'h0;
  localparam logic ResetCfgFailSafe = 1'h1;

  // Sequencer states
  typedef enum logic [1:0] {
    FOL_INIT = 2'b00,
    FOL_RUN = 2'b01
  } fol_state_e;
endpackage

// ---- rtl/fol_fail_output.sv ----
/*
  Fail output logic: collects failure conditions, drives the low-side fail
  output, keeps the sticky fail-active flag, and decodes the configuration.
  Assumes pin inputs are asynchronous; event inputs are one-cycle pulses from
  logic on the same clock; software reset pulse comes from the mode logic.
*/
// Contract
// [RQ1] Any failure turns the fail output on and sets the fail-active flag.
// [RQ2] Watchdog failures trip the output after one or two, per configuration.
// [RQ3] Level-two thermal shutdown or supply short to ground trips the output.
// [RQ4] Supply overvoltage trips the output only while its reset enable is set.
// [RQ5] The fourth consecutive supply undervoltage detection trips the output.
// [RQ6] Select bit 1 means one watchdog failure, pull-up absent means fail-safe.
// [RQ7] Output turns off only once no failure remains and the host cleared the flag.
// [RQ8] After a watchdog failure, release also needs a good watchdog trigger.
// [RQ9] The output asserts for every failure, fail-safe or not.
// [RQ10] The interrupt pin configuration level is filtered for 8 us.
// [RQ11] The fail/test pin level is filtered for 64 us before a change counts.
// [RQ12] A software reset re-evaluates the configuration from pins and bit.
// [RQ13] After reset the output is off and the flag clear; the flag is sticky.
module fol_fail_output #(
  parameter int CfgCycles = fol_pkg::CfgFilterCycles,
  parameter int TestCycles = fol_pkg::TestFilterCycles
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Failure events, same clock
  input wire logic wdFailPulse,
  input wire logic wdGoodTrigger,
  input wire logic thermal_shutdown_level_two,
  input wire logic ioShortGnd,
  input wire logic ioOvervoltage,
  input wire logic ioUndervoltPulse,
  input wire logic ioSupplyGoodPulse,
  // Control bits
  input wire logic io_overvoltage_reset_enable,
  input wire logic config_select_bit,
  input wire logic flagClearPulse,
  input wire logic softResetPulse,
  // Pins, asynchronous
  input wire logic interruptPinSense,
  input wire logic failTestPinSense,
  // Outputs
  output logic fail_out_pin,
  output logic fail_active_flag,
  output logic cfgSingleWd,
  output logic cfgFailSafe,
  output logic testModeLevel,
  output logic cfgValid
);
  import fol_pkg::*;

  typedef struct packed {
    logic [1:0] intSync;
    logic intLast;
    logic [1:0] testSync;
    fol_state_e state;
    logic [FiltW-1:0] cfgCnt;
    logic [FiltW-1:0] testCnt;
    logic cfgValid;
    logic cfgSingleWd;
    logic cfgFailSafe;
    logic testLevel;
    logic [1:0] wdCnt;
    logic wdLatched;
    logic [2:0] uvCnt;
    logic uvLatched;
    logic failOut;
    logic flag;
    logic [FiltW-1:0] intHeld; // Checker helper, not used by the logic
  } fol_s;

  fol_s r;
  fol_s next_r;
  logic rstN;
  logic [1:0] rstSync;
  logic failNow;
  logic [1:0] wdNeed;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'h1};
    end
  end
  assign rstN = rstSync[1];

  // Combined live failure term
  always_comb begin
    wdNeed = r.cfgSingleWd ? 2'h1 : 2'h2; // see [RQ2] see [RQ6]
    failNow = r.wdLatched || r.uvLatched
      || thermal_shutdown_level_two || ioShortGnd // see [RQ3]
      || (ioOvervoltage && io_overvoltage_reset_enable); // see [RQ4]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_r = r;
    // Pins through two flip-flops; a third copy of the config level feeds the filter
    next_r.intSync = {r.intSync[0], interruptPinSense};
    next_r.intLast = r.intSync[1];
    next_r.testSync = {r.testSync[0], failTestPinSense};
    // Fail/test pin filter: level accepted after stable period
    if (r.testSync[1] == r.testLevel) begin
      next_r.testCnt = '0;
    end else if (r.testCnt >= FiltW'(TestCycles - 1)) begin
      next_r.testCnt = '0;
      next_r.testLevel = r.testSync[1]; // see [RQ11]
    end else begin
      next_r.testCnt = r.testCnt + FiltW'(1);
    end
    // Configuration sampling sequencer
    case (r.state)
      FOL_INIT: begin
        if (r.intSync[1] != r.intLast) begin
          next_r.cfgCnt = '0;
        end else if (r.cfgCnt >= FiltW'(CfgCycles - 1)) begin
          next_r.cfgSingleWd = config_select_bit; // see [RQ6]
          next_r.cfgFailSafe = !r.intSync[1]; // see [RQ6] see [RQ10]
          next_r.cfgValid = 1'h1;
          next_r.state = FOL_RUN;
        end else begin
          next_r.cfgCnt = r.cfgCnt + FiltW'(1);
        end
      end
      FOL_RUN: begin
        if (softResetPulse) begin
          next_r.state = FOL_INIT; // see [RQ12]
          next_r.cfgCnt = '0;
          next_r.cfgValid = 1'h0;
        end
      end
      default: begin
        next_r.state = FOL_INIT;
      end
    endcase
    // Watchdog failure count; good trigger clears
    if (wdGoodTrigger) begin
      next_r.wdCnt = 2'h0;
      next_r.wdLatched = 1'h0; // see [RQ8]
    end else if (wdFailPulse) begin
      if (r.wdCnt + 2'h1 >= wdNeed) begin
        next_r.wdLatched = 1'h1; // see [RQ2]
        next_r.wdCnt = wdNeed;
      end else begin
        next_r.wdCnt = r.wdCnt + 2'h1;
      end
    end
    // Consecutive undervoltage count; good supply breaks the run
    if (ioSupplyGoodPulse && !ioUndervoltPulse) begin
      next_r.uvCnt = 3'h0;
      next_r.uvLatched = 1'h0;
    end else if (ioUndervoltPulse && !r.uvLatched) begin
      next_r.uvCnt = r.uvCnt + 3'h1;
      if (r.uvCnt + 3'h1 >= 3'(UvTripCount)) begin
        next_r.uvLatched = 1'h1; // see [RQ5]
      end
    end
    // Sticky flag, set wins over clear
    if (failNow) begin
      next_r.flag = 1'h1; // see [RQ1] see [RQ13]
    end else if (flagClearPulse) begin
      next_r.flag = 1'h0; // see [RQ7]
    end
    // Output on for any failure, off once cleared and no failure
    if (failNow) begin
      next_r.failOut = 1'h1; // see [RQ1] see [RQ9]
    end else if (!r.flag) begin
      next_r.failOut = 1'h0; // see [RQ7] see [RQ8]
    end
    // Checker helper: cycles the synced config level has held still
    if (r.intSync[1] != r.intLast) begin
      next_r.intHeld = '0;
    end else if (r.intHeld != '1) begin
      next_r.intHeld = r.intHeld + FiltW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      r.intSync <= 2'h0;
      r.intLast <= 1'h0;
      r.testSync <= 2'h0;
      r.state <= FOL_INIT;
      r.cfgCnt <= '0;
      r.testCnt <= '0;
      r.cfgValid <= 1'h0;
      r.cfgSingleWd <= ResetCfgSingleWd;
      r.cfgFailSafe <= ResetCfgFailSafe;
      r.testLevel <= 1'h0;
      r.wdCnt <= 2'h0;
      r.wdLatched <= 1'h0;
      r.uvCnt <= 3'h0;
      r.uvLatched <= 1'h0;
      r.failOut <= ResetFailOut; // see [RQ13]
      r.flag <= ResetFlag;
      r.intHeld <= '0;
    end else begin
      r.intSync <= next_r.intSync;
      r.intLast <= next_r.intLast;
      r.testSync <= next_r.testSync;
      r.state <= next_r.state;
      r.cfgCnt <= next_r.cfgCnt;
      r.testCnt <= next_r.testCnt;
      r.cfgValid <= next_r.cfgValid;
      r.cfgSingleWd <= next_r.cfgSingleWd;
      r.cfgFailSafe <= next_r.cfgFailSafe;
      r.testLevel <= next_r.testLevel;
      r.wdCnt <= next_r.wdCnt;
      r.wdLatched <= next_r.wdLatched;
      r.uvCnt <= next_r.uvCnt;
      r.uvLatched <= next_r.uvLatched;
      r.failOut <= next_r.failOut;
      r.flag <= next_r.flag;
      r.intHeld <= next_r.intHeld;
    end
  end

  // Outputs straight from flip-flops
  assign fail_out_pin = r.failOut;
  assign fail_active_flag = r.flag;
  assign cfgSingleWd = r.cfgSingleWd;
  assign cfgFailSafe = r.cfgFailSafe;
  assign testModeLevel = r.testLevel;
  assign cfgValid = r.cfgValid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_flag_on_fail;
    @(posedge clock) disable iff (!rstN) failNow |=> r.flag && r.failOut;
  endproperty
  a_flag_on_fail: assert property (p_flag_on_fail) else $error("flag not set"); // see [RQ1]

  property p_therm;
    @(posedge clock) disable iff (!rstN) thermal_shutdown_level_two |=> fail_out_pin;
  endproperty
  a_therm: assert property (p_therm) else $error("thermal no fail"); // see [RQ3]

  property p_ov_gated;
    @(posedge clock) disable iff (!rstN)
      (ioOvervoltage && io_overvoltage_reset_enable) |=> fail_out_pin;
  endproperty
  a_ov_gated: assert property (p_ov_gated) else $error("overvoltage no fail"); // see [RQ4]

  property p_single_wd;
    @(posedge clock) disable iff (!rstN)
      (r.cfgSingleWd && wdFailPulse && !wdGoodTrigger) |=> ##1 fail_out_pin;
  endproperty
  a_single_wd: assert property (p_single_wd) else $error("single wd no fail"); // see [RQ2]

  property p_uv_early;
    @(posedge clock) disable iff (!rstN) (r.uvCnt < 3'h3) |=> !r.uvLatched || $past(r.uvLatched);
  endproperty
  a_uv_early: assert property (p_uv_early) else $error("uv tripped early"); // see [RQ5]

  property p_hold;
    @(posedge clock) disable iff (!rstN) (fail_out_pin && fail_active_flag) |=> fail_out_pin;
  endproperty
  a_hold: assert property (p_hold) else $error("output released early"); // see [RQ7]

  property p_wd_hold;
    @(posedge clock) disable iff (!rstN)
      (r.wdLatched && !wdGoodTrigger) |=> r.wdLatched;
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("wd latch lost"); // see [RQ8]

  property p_cfg_filter;
    @(posedge clock) disable iff (!rstN)
      $rose(cfgValid) |-> r.intHeld >= FiltW'(CfgCycles) && cfgFailSafe == !r.intLast;
  endproperty
  a_cfg_filter: assert property (p_cfg_filter) else $error("cfg decode"); // see [RQ10]

  property p_soft_reset;
    @(posedge clock) disable iff (!rstN)
      (r.state == FOL_RUN && softResetPulse) |=> !cfgValid;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("no re-eval"); // see [RQ12]

  property p_ov_refused;
    @(posedge clock) disable iff (!rstN)
      (!fail_out_pin && !io_overvoltage_reset_enable && !thermal_shutdown_level_two
        && !ioShortGnd && !r.wdLatched && !r.uvLatched) |=> !fail_out_pin;
  endproperty
  a_ov_refused: assert property (p_ov_refused) else $error("ov not gated"); // see [RQ4]

  property p_uv_trip;
    @(posedge clock) disable iff (!rstN)
      (ioUndervoltPulse && r.uvCnt == 3'h3) |=> ##1 fail_out_pin;
  endproperty
  a_uv_trip: assert property (p_uv_trip) else $error("uv no fail"); // see [RQ5]

  property p_release;
    @(posedge clock) disable iff (!rstN)
      $fell(fail_out_pin) |-> !$past(fail_active_flag) && !$past(failNow);
  endproperty
  a_release: assert property (p_release) else $error("release with flag set"); // see [RQ7]

  property p_flag_sticky;
    @(posedge clock) disable iff (!rstN)
      (fail_active_flag && !flagClearPulse) |=> fail_active_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // see [RQ13]

  c_fail: cover property (@(posedge clock) disable iff (!rstN) $rose(fail_out_pin));
  c_release: cover property (@(posedge clock) disable iff (!rstN) $fell(fail_out_pin));
  c_uv: cover property (@(posedge clock) disable iff (!rstN) $rose(r.uvLatched));
  c_test: cover property (@(posedge clock) disable iff (!rstN) $changed(testModeLevel));
  c_cfg: cover property (@(posedge clock) disable iff (!rstN) $rose(cfgValid));
endmodule

// ---- sim/fol_load_model.sv ----
/*
  Far side of the fail output: a load switch on the fail pin and a board
  jumper on the shared fail/test pin.
  Assumes the fail output and the bench share one clock.
*/
module fol_load_model (
  // Clock
  input wire logic clock,
  // Switch state and jumper
  input wire logic failOn,
  input wire logic testJumperLow,
  // Pin level and load
  output logic failTestPinSense,
  output logic loadOn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-up holds the pin high unless the switch or jumper pulls it low
  assign failTestPinSense = ~testJumperLow & ~failOn;
  // Load follows the switch one cycle late
  always_ff @(posedge clock) begin
    loadOn <= failOn;
  end
endmodule

// ---- sim/tb.sv ----
/*
  Testbench for the fail output logic: failure causes, clearing, config.
  Assumes short filter parameters and the load model beside the design.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, arst_n, wdFailPulse, wdGoodTrigger, thermal_shutdown_level_two;
  logic ioShortGnd, ioOvervoltage, ioUndervoltPulse, ioSupplyGoodPulse;
  logic io_overvoltage_reset_enable, config_select_bit, flagClearPulse;
  logic softResetPulse, interruptPinSense, failTestPinSense, testJumperLow, loadOn;
  logic fail_out_pin, fail_active_flag, cfgSingleWd, cfgFailSafe, testModeLevel, cfgValid;
  int nErrors = 0;
  int checks = 0;

  fol_fail_output #(.CfgCycles(4), .TestCycles(8)) u_fol_fail_output (
    .clock, .arst_n, .wdFailPulse, .wdGoodTrigger, .thermal_shutdown_level_two,
    .ioShortGnd, .ioOvervoltage, .ioUndervoltPulse, .ioSupplyGoodPulse,
    .io_overvoltage_reset_enable, .config_select_bit, .flagClearPulse,
    .softResetPulse, .interruptPinSense, .failTestPinSense, .fail_out_pin,
    .fail_active_flag, .cfgSingleWd, .cfgFailSafe, .testModeLevel, .cfgValid
  );
  fol_load_model u_fol_load_model (
    .clock, .failOn(fail_out_pin), .testJumperLow, .failTestPinSense, .loadOn
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end

  // Wait n edges, then step off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask

  // Strobe selectors for pulse
  localparam int WdFail = 0;
  localparam int WdGood = 1;
  localparam int UvDet = 2;
  localparam int SupplyGood = 3;
  localparam int FlagClear = 4;
  localparam int SoftReset = 5;

  // One-cycle pulse on the chosen strobe with a gap after it
  task automatic pulse(input int which);
    case (which)
      WdFail: wdFailPulse = 1;
      WdGood: wdGoodTrigger = 1;
      UvDet: ioUndervoltPulse = 1;
      SupplyGood: ioSupplyGoodPulse = 1;
      FlagClear: flagClearPulse = 1;
      default: softResetPulse = 1;
    endcase
    step(1);
    {wdFailPulse, wdGoodTrigger, ioUndervoltPulse} = 3'h0;
    {ioSupplyGoodPulse, flagClearPulse, softResetPulse} = 3'h0;
    step(1);
  endtask

  // Compare one bit
  task automatic cmp(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Counts and verdict
  task automatic endSim();
    $display("checks %0d mismatches %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset state and sampled configuration
  task automatic t_reset();
    cmp("fail_out_pin", 0, fail_out_pin);
    cmp("fail_active_flag", 0, fail_active_flag);
    cmp("cfgValid", 0, cfgValid);
    step(20);
    cmp("cfgValid", 1, cfgValid);
    cmp("cfgSingleWd", 0, cfgSingleWd);
    cmp("cfgFailSafe", 0, cfgFailSafe);
    cmp("testModeLevel", 1, testModeLevel);
    $display("test reset done");
  endtask

  // Level causes: set, refused clear, sticky flag, release
  task automatic t_level();
    for (int i = 0; i < 3; i++) begin
      thermal_shutdown_level_two = (i == 0);
      ioShortGnd = (i == 1);
      io_overvoltage_reset_enable = (i == 2);
      ioOvervoltage = (i == 2);
      step(3);
      cmp("fail_out_pin", 1, fail_out_pin);
      cmp("fail_active_flag", 1, fail_active_flag);
      cmp("loadOn", 1, loadOn);
      pulse(FlagClear);
      step(2);
      cmp("fail_active_flag", 1, fail_active_flag);
      {thermal_shutdown_level_two, ioShortGnd, ioOvervoltage} = 3'h0;
      step(3);
      cmp("fail_active_flag", 1, fail_active_flag);
      cmp("fail_out_pin", 1, fail_out_pin);
      pulse(FlagClear);
      step(2);
      cmp("fail_out_pin", 0, fail_out_pin);
      cmp("fail_active_flag", 0, fail_active_flag);
    end
    io_overvoltage_reset_enable = 0;
    ioOvervoltage = 1;
    step(4);
    cmp("fail_out_pin", 0, fail_out_pin);
    cmp("fail_active_flag", 0, fail_active_flag);
    ioOvervoltage = 0;
    $display("test level causes done");
  endtask

  // Undervoltage run broken, then four in a row
  task automatic t_uv();
    repeat (3) pulse(UvDet);
    pulse(SupplyGood);
    repeat (3) pulse(UvDet);
    step(3);
    cmp("fail_out_pin", 0, fail_out_pin);
    pulse(UvDet);
    step(2);
    cmp("fail_out_pin", 1, fail_out_pin);
    pulse(SupplyGood);
    pulse(FlagClear);
    step(2);
    cmp("fail_out_pin", 0, fail_out_pin);
    $display("test undervoltage done");
  endtask

  // Watchdog counts, release after good trigger, soft reset re-config
  task automatic t_wd();
    pulse(WdFail);
    step(3);
    cmp("fail_out_pin", 0, fail_out_pin);
    pulse(WdFail);
    step(2);
    cmp("fail_out_pin", 1, fail_out_pin);
    pulse(FlagClear);
    step(2);
    cmp("fail_out_pin", 1, fail_out_pin);
    pulse(WdGood);
    pulse(FlagClear);
    step(2);
    cmp("fail_out_pin", 0, fail_out_pin);
    interruptPinSense = 0;
    config_select_bit = 1;
    pulse(SoftReset);
    cmp("cfgValid", 0, cfgValid);
    step(20);
    cmp("cfgSingleWd", 1, cfgSingleWd);
    cmp("cfgFailSafe", 1, cfgFailSafe);
    pulse(WdFail);
    step(2);
    cmp("fail_out_pin", 1, fail_out_pin);
    pulse(WdGood);
    pulse(FlagClear);
    $display("test watchdog done");
  endtask

  // Fail/test pin filter
  task automatic t_test();
    step(20);
    testJumperLow = 1;
    step(4);
    cmp("testModeLevel", 1, testModeLevel);
    step(16);
    cmp("testModeLevel", 0, testModeLevel);
    testJumperLow = 0;
    step(20);
    cmp("testModeLevel", 1, testModeLevel);
    $display("test pin filter done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {wdFailPulse, wdGoodTrigger, thermal_shutdown_level_two, ioShortGnd} = 4'h0;
    {ioOvervoltage, ioUndervoltPulse, ioSupplyGoodPulse, flagClearPulse} = 4'h0;
    {io_overvoltage_reset_enable, config_select_bit, softResetPulse} = 3'h0;
    interruptPinSense = 1;
    testJumperLow = 0;
    arst_n = 0;
    step(12);
    arst_n = 1;
    step(6);
    t_reset();
    t_level();
    t_uv();
    t_wd();
    t_test();
    endSim();
  end

  // Watchdog against a hang
  initial begin
    #300000;
    nErrors++;
    endSim();
  end
endmodule
